// *** logic/sac_ctrl.v ***
// shared converter core timing, reference status and wishbone register file
//
// Notes on behaviour
// R1 - the core clock is the source clock divided by twice the divider code.
// R2 - the sample time is the sample count field plus two core clocks.
// R3 - software must not use early codes 110 or 111 at the reduced resolution 01.
// R4 - software sets the reference error interrupt enable only after the module is on.
// R5 - bit 15 of the sample and status register reads the band gap ready level.
// R6 - bit 14 is set when the band gap is lost while the module is on.
// R7 - bits 13 to 10 of that register read zero and ignore writes.
// R8 - the early interrupt comes code plus one core clocks before data is ready.
`timescale 1ns/1ps
`include "sac_defines.vh"

module sac_ctrl
(
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output wire ack_o,
	// analog status pin
	input wire band_gap_ok_i,
	// converter status
	output wire core_tick_o,
	output wire sampling_o,
	output wire busy_o,
	output wire early_irq_o,
	output wire data_ready_o,
	output wire reference_ready_o,
	// interrupt
	output wire irq_o
);

	reg ack;
	reg converter_module_on;
	reg ref_error_irq_enable;
	reg [1:0] shared_core_resolution;
	reg start;
	reg [6:0] shared_core_clock_divider;
	reg [2:0] shared_early_irq_time;
	reg [9:0] shared_sample_time_count;
	reg reference_error_flag;
	reg [`SAC_IRQ_W-1:0] irq_status;
	reg [`SAC_IRQ_W-1:0] irq_mask;
	reg bg_meta;
	reg bg_sync;
	reg bg_prev;
	reg [31:0] next_dat;
	wire bus_req;
	wire wr_en;
	wire rd_cycle;
	wire [31:0] ctrl_val;
	wire [31:0] cfg_val;
	wire [31:0] sr_val;
	wire [`SAC_IRQ_W-1:0] irq_events;
	wire ref_lost;
	wire [31:0] wdat_ctrl;
	wire [31:0] wdat_cfg;
	wire [31:0] wdat_sr;
	wire [31:0] wdat_irq;

	// ****************************************
	// byte lane merge
	// ****************************************
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] wr;
		input [3:0] sel;
		integer i;
		begin
			lane_merge = old;
			for (i = 0; i < 4; i = i + 1)
			begin
				if (sel[i])
				begin
					lane_merge[i*8 +: 8] = wr[i*8 +: 8];
				end
			end
		end
	endfunction

	// ****************************************
	// wishbone handshake
	// ****************************************
	assign bus_req = cyc_i & stb_i;
	assign ack_o = ack & bus_req;
	assign wr_en = ack_o & we_i;
	assign rd_cycle = bus_req & ~ack;

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack <= 1'b0;
		end
		else
		begin
			ack <= bus_req & ~ack;
		end
	end

	// ****************************************
	// band gap synchroniser
	// ****************************************
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bg_meta <= 1'b0;
			bg_sync <= 1'b0;
			bg_prev <= 1'b0;
		end
		else
		begin
			bg_meta <= band_gap_ok_i;
			bg_sync <= bg_meta;
			bg_prev <= bg_sync;
		end
	end

	assign reference_ready_o = bg_sync; // see R5
	assign ref_lost = converter_module_on & bg_prev & ~bg_sync; // see R6

	// ****************************************
	// register read values
	// ****************************************
	assign ctrl_val = {27'h0, 1'b0, shared_core_resolution,
		ref_error_irq_enable, converter_module_on};
	assign cfg_val = {21'h0, shared_early_irq_time, 1'b0, shared_core_clock_divider};
	assign sr_val = {16'h0000, bg_sync, reference_error_flag, 4'h0,
		shared_sample_time_count}; // see R5, see R6, see R7

	always @*
	begin
		case (adr_i)
			`SAC_OFS_CTRL: next_dat = ctrl_val;
			`SAC_OFS_CORE_CFG: next_dat = cfg_val;
			`SAC_OFS_SAMP_REF: next_dat = sr_val;
			`SAC_OFS_IRQ_STAT: next_dat = {29'h0, irq_status};
			`SAC_OFS_IRQ_MASK: next_dat = {29'h0, irq_mask};
			default: next_dat = 32'h00000000;
		endcase
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dat_o <= 32'h00000000;
		end
		else if (rd_cycle)
		begin
			dat_o <= next_dat;
		end
	end

	// ****************************************
	// register writes
	// ****************************************
	assign wdat_ctrl = lane_merge(ctrl_val, dat_i, sel_i);
	assign wdat_cfg = lane_merge(cfg_val, dat_i, sel_i);
	assign wdat_sr = lane_merge(sr_val, dat_i, sel_i);
	assign wdat_irq = lane_merge(32'h00000000, dat_i, sel_i);

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			{shared_core_resolution, ref_error_irq_enable, converter_module_on} <= `SAC_RST_CTRL;
			start <= 1'b0;
			shared_core_clock_divider <= `SAC_RST_DIV;
			shared_early_irq_time <= `SAC_RST_EIRQ;
			shared_sample_time_count <= `SAC_RST_SAMC;
			irq_mask <= `SAC_RST_IRQ;
		end
		else
		begin
			start <= 1'b0;
			if (wr_en && adr_i == `SAC_OFS_CTRL)
			begin
				converter_module_on <= wdat_ctrl[`SAC_CTRL_ON];
				ref_error_irq_enable <= wdat_ctrl[`SAC_CTRL_REFERENCE_ERROR_FLAG_IE]; // see R4
				shared_core_resolution <= wdat_ctrl[`SAC_CTRL_RES_HI:`SAC_CTRL_RES_LO]; // see R3
				start <= wdat_ctrl[`SAC_CTRL_START];
			end
			if (wr_en && adr_i == `SAC_OFS_CORE_CFG)
			begin
				shared_core_clock_divider <= wdat_cfg[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO];
				shared_early_irq_time <= wdat_cfg[`SAC_CFG_EIRQ_HI:`SAC_CFG_EIRQ_LO];
			end
			if (wr_en && adr_i == `SAC_OFS_SAMP_REF)
			begin
				// status bits and bits 13..10 are not writable
				shared_sample_time_count <= wdat_sr[`SAC_SR_SAMC_HI:`SAC_SR_SAMC_LO]; // see R7
			end
			if (wr_en && adr_i == `SAC_OFS_IRQ_MASK)
			begin
				irq_mask <= wdat_irq[`SAC_IRQ_W-1:0];
			end
		end
	end

	// ****************************************
	// reference error flag
	// ****************************************
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			reference_error_flag <= 1'b0;
		end
		else if (ref_lost)
		begin
			reference_error_flag <= 1'b1; // see R6
		end
		else if (!converter_module_on)
		begin
			reference_error_flag <= 1'b0;
		end
	end

	// ****************************************
	// interrupt status, write one to clear
	// ****************************************
	assign irq_events[`SAC_IRQ_EARLY] = early_irq_o;
	assign irq_events[`SAC_IRQ_DONE] = data_ready_o;
	assign irq_events[`SAC_IRQ_REFERENCE_ERROR_FLAG] = ref_lost & ref_error_irq_enable; // see R4

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_status <= `SAC_RST_IRQ;
		end
		else if (wr_en && adr_i == `SAC_OFS_IRQ_STAT)
		begin
			// set wins over clear
			irq_status <= (irq_status & ~wdat_irq[`SAC_IRQ_W-1:0]) | irq_events;
		end
		else
		begin
			irq_status <= irq_status | irq_events;
		end
	end

	assign irq_o = |(irq_status & irq_mask);

	// ****************************************
	// core clock and conversion sequence
	// ****************************************
	sac_clock_div u_div
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(converter_module_on),
		.divider_i(shared_core_clock_divider),
		.tick_o(core_tick_o)
	); // see R1

	sac_conv_seq u_seq
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(converter_module_on),
		.start_i(start),
		.tick_i(core_tick_o),
		.sample_count_i(shared_sample_time_count),
		.resolution_i(shared_core_resolution),
		.early_time_i(shared_early_irq_time),
		.sampling_o(sampling_o),
		.busy_o(busy_o),
		.early_o(early_irq_o),
		.done_o(data_ready_o)
	); // see R2, see R8

endmodule // sac_ctrl

// *** logic/sac_defines.vh ***
// register map, field positions, reset values and timing for the shared converter control
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define SAC_OFS_CTRL 8'h00
`define SAC_OFS_CORE_CFG 8'h04
`define SAC_OFS_SAMP_REF 8'h08
`define SAC_OFS_IRQ_STAT 8'h0c
`define SAC_OFS_IRQ_MASK 8'h10

// ****************************************
// control register fields
// ****************************************
`define SAC_CTRL_ON 0
`define SAC_CTRL_REFERENCE_ERROR_FLAG_IE 1
`define SAC_CTRL_RES_LO 2
`define SAC_CTRL_RES_HI 3
`define SAC_CTRL_START 4

// ****************************************
// core configuration fields
// ****************************************
`define SAC_CFG_DIV_LO 0
`define SAC_CFG_DIV_HI 6
`define SAC_CFG_EIRQ_LO 8
`define SAC_CFG_EIRQ_HI 10

// ****************************************
// sample time and reference status fields
// ****************************************
`define SAC_SR_SAMC_LO 0
`define SAC_SR_SAMC_HI 9
`define SAC_SR_ERR 14
`define SAC_SR_RDY 15

// ****************************************
// interrupt status and mask bits
// ****************************************
`define SAC_IRQ_EARLY 0
`define SAC_IRQ_DONE 1
`define SAC_IRQ_REFERENCE_ERROR_FLAG 2
`define SAC_IRQ_W 3

// ****************************************
// reset values
// ****************************************
`define SAC_RST_CTRL 4'h0
`define SAC_RST_DIV 7'h0
`define SAC_RST_EIRQ 3'h0
`define SAC_RST_SAMC 10'h0
`define SAC_RST_IRQ 3'h0

// ****************************************
// timing in core clocks
// ****************************************
`define SAC_SAMPLE_EXTRA 12'h002
`define SAC_CONV_RES_00 12'h006
`define SAC_CONV_RES_01 12'h008
`define SAC_CONV_RES_10 12'h00a
`define SAC_CONV_RES_11 12'h00c

`endif

// *** logic/sac_clock_div.v ***
// core clock divider producing a one-cycle core clock tick
`timescale 1ns/1ps
`include "sac_defines.vh"

module sac_clock_div
(
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// control
	input wire enable_i,
	input wire [6:0] divider_i,
	// tick out
	output reg tick_o
);

	reg [7:0] count;
	wire [7:0] last;

	// ****************************************
	// 2*code source periods per core clock
	// ****************************************
	// code 0 is handled as code 1
	assign last = (divider_i == 7'h00) ? 8'h01 : {divider_i, 1'b0} - 8'h01; // see R1

	always @(posedge clk_i)
	begin
		if (rst_i || !enable_i)
		begin
			count <= 8'h00;
			tick_o <= 1'b0;
		end
		else if (count >= last)
		begin
			count <= 8'h00;
			tick_o <= 1'b1; // see R1
		end
		else
		begin
			count <= count + 8'h01;
			tick_o <= 1'b0;
		end
	end

endmodule // sac_clock_div

// *** logic/sac_conv_seq.v ***
// shared core conversion sequencer: sample time, conversion and early interrupt
`timescale 1ns/1ps
`include "sac_defines.vh"

module sac_conv_seq
(
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// control
	input wire enable_i,
	input wire start_i,
	input wire tick_i,
	input wire [9:0] sample_count_i,
	input wire [1:0] resolution_i,
	input wire [2:0] early_time_i,
	// status
	output reg sampling_o,
	output reg busy_o,
	output reg early_o,
	output reg done_o
);

	reg [11:0] remaining;
	reg [11:0] conv_len;
	wire [11:0] total;
	wire [11:0] early_at;

	function [11:0] conv_clocks;
		input [1:0] res;
		begin
			case (res)
				2'b00: conv_clocks = `SAC_CONV_RES_00;
				2'b01: conv_clocks = `SAC_CONV_RES_01;
				2'b10: conv_clocks = `SAC_CONV_RES_10;
				default: conv_clocks = `SAC_CONV_RES_11;
			endcase
		end
	endfunction

	// ****************************************
	// lengths in core clocks
	// ****************************************
	assign total = {2'b00, sample_count_i} + `SAC_SAMPLE_EXTRA
		+ conv_clocks(resolution_i); // see R2
	assign early_at = {9'h0, early_time_i} + 12'h001; // see R8

	// ****************************************
	// countdown to data ready
	// ****************************************
	always @(posedge clk_i)
	begin
		if (rst_i || !enable_i)
		begin
			remaining <= 12'h000;
			conv_len <= 12'h000;
			busy_o <= 1'b0;
			sampling_o <= 1'b0;
			early_o <= 1'b0;
			done_o <= 1'b0;
		end
		else
		begin
			early_o <= 1'b0;
			done_o <= 1'b0;
			if (!busy_o && start_i)
			begin
				remaining <= total;
				conv_len <= conv_clocks(resolution_i);
				busy_o <= 1'b1;
				sampling_o <= 1'b1;
				early_o <= (total <= early_at); // see R8
			end
			else if (busy_o && tick_i)
			begin
				remaining <= remaining - 12'h001;
				sampling_o <= (remaining - 12'h001) > conv_len; // see R2
				if (remaining - 12'h001 == early_at)
				begin
					early_o <= 1'b1; // see R8
				end
				if (remaining == 12'h001)
				begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end

endmodule // sac_conv_seq

// *** testbench/sac_ctrl_properties.sv ***
// concurrent checks on the shared converter control ports
`timescale 1ns/1ps

module sac_ctrl_properties
(
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// bus
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire ack_o,
	// status
	input wire band_gap_ok_i,
	input wire core_tick_o,
	input wire sampling_o,
	input wire busy_o,
	input wire early_irq_o,
	input wire data_ready_o,
	input wire reference_ready_o,
	input wire irq_o
);
	reg [2:0] code;
	reg [3:0] lead;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence rd_seq(a);
		ack_o && !we_i && adr_i == a;
	endsequence
	// ****
	// early code and ticks after early
	// ****
	always @(posedge clk_i)
	begin
		if (rst_i)
			code <= 3'h0;
		else if (ack_o && we_i && adr_i == 8'h04 && sel_i[1])
			code <= dat_i[10:8];
		if (rst_i || early_irq_o)
			lead <= 4'h0;
		else if (core_tick_o && lead != 4'hf)
			lead <= lead + 4'h1;
	end
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i) && $past(stb_i)) else $error("stray ack");
	samp_busy_a: assert property (sampling_o |-> busy_o) else $error("sampling idle");
	tick_gap_a: assert property (core_tick_o |=> !core_tick_o) else $error("tick");
	rdy_sync_a: assert property ($changed(reference_ready_o) |->
		reference_ready_o == $past(band_gap_ok_i, 2)) else $error("ready sync");
	rsvd_zero_a: assert property (rd_seq(8'h08) |-> dat_o[13:10] == 4'h0)
		else $error("reserved bits");
	rdy_bit_a: assert property (rd_seq(8'h08) |-> dat_o[15] == $past(reference_ready_o))
		else $error("ready bit");
	early_lead_a: assert property (data_ready_o |->
		lead + {3'h0, core_tick_o} == {1'h0, code} + 4'h1) else $error("early lead");
	done_busy_a: assert property (data_ready_o |-> $past(busy_o)) else $error("done");
endmodule // sac_ctrl_properties

bind sac_ctrl sac_ctrl_properties u_sac_ctrl_properties (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o), .band_gap_ok_i(band_gap_ok_i), .core_tick_o(core_tick_o),
	.sampling_o(sampling_o), .busy_o(busy_o), .early_irq_o(early_irq_o),
	.data_ready_o(data_ready_o), .reference_ready_o(reference_ready_o), .irq_o(irq_o));

// *** testbench/tb_sac_ctrl.sv ***
// bench for the shared converter control
`timescale 1ns/1ps

module tb_sac_ctrl;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, band_gap_ok_i;
	logic [3:0] sel_i, lanes;
	logic [7:0] adr_i;
	logic [31:0] dat_i, q;
	wire [31:0] dat_o;
	wire ack_o, core_tick_o, sampling_o, busy_o, early_irq_o, data_ready_o;
	wire reference_ready_o, irq_o;
	wire [2:0] ev = {data_ready_o, core_tick_o, ack_o};
	int fails, comparisons, n, m, k, t0;
	sac_ctrl u_sac_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.band_gap_ok_i(band_gap_ok_i), .core_tick_o(core_tick_o), .sampling_o(sampling_o),
		.busy_o(busy_o), .early_irq_o(early_irq_o), .data_ready_o(data_ready_o),
		.reference_ready_o(reference_ready_o), .irq_o(irq_o));
	initial
	begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	task end_of_test;
	begin
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	// waits for an event, counting ticks while busy
	task wt(input int s);
	begin
		k = 0;
		n = 0;
		m = 0;
		do
		begin
			@(negedge clk_i);
			k++;
			if ((busy_o & core_tick_o) === 1'h1)
				n++;
			if ((sampling_o & core_tick_o) === 1'h1)
				m++;
		end
		while (ev[s] !== 1'h1 && k < 4000);
		if (ev[s] !== 1'h1)
		begin
			fails++;
			end_of_test;
		end
	end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		sel_i <= lanes;
		dat_i <= d;
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (ack_o !== 1'h1 && k < 100);
		if (ack_o !== 1'h1)
		begin
			fails++;
			end_of_test;
		end
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
	end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
	begin
		bus(1'h0, a, 32'h0);
		chk(q, e);
	end
	endtask
	task per(input int c);
	begin
		wr(8'h04, c);
		wt(1);
		wt(1);
		chk(k, 2 * c);
	end
	endtask
	task conv(input logic [31:0] cfg, input logic [31:0] samc, input logic [31:0] ctl);
	begin
		wr(8'h04, cfg);
		wr(8'h08, samc);
		wr(8'h00, ctl);
		wt(2);
	end
	endtask
	task ci(input logic e);
	begin
		@(negedge clk_i);
		chk({31'h0, irq_o}, {31'h0, e});
	end
	endtask
	initial
	begin
		rst_i = 1'h1;
		cyc_i = 1'h0;
		stb_i = 1'h0;
		we_i = 1'h0;
		adr_i = 8'h0;
		sel_i = 4'hf;
		lanes = 4'hf;
		dat_i = 32'h0;
		band_gap_ok_i = 1'h1;
		fails = 0;
		comparisons = 0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		rd(8'h08, 32'h8000);
		wr(8'h08, 32'hffffffff);
		rd(8'h08, 32'h83ff);
		lanes = 4'h1;
		wr(8'h08, 32'h0);
		lanes = 4'hf;
		rd(8'h08, 32'h8300);
		rd(8'h20, 32'h0);
		wr(8'h00, 32'h1);
		per(1);
		per(2);
		wr(8'h10, 32'h7);
		conv(32'h201, 32'h0, 32'h11);
		chk(n, 32'h8);
		chk(m, 32'h2);
		t0 = n;
		ci(1'h1);
		rd(8'h0c, 32'h3);
		wr(8'h0c, 32'h3);
		ci(1'h0);
		conv(32'h201, 32'h3ff, 32'h11);
		chk(n - t0, 32'h3ff);
		chk(m, 32'h401);
		conv(32'h201, 32'h0, 32'h19);
		chk(n, 32'hc);
		conv(32'h201, 32'h0, 32'h1d);
		chk(n, 32'he);
		for (int c = 0; c < 7; c++)
			conv(32'h1 + (c << 8), 32'h1, 32'h11);
		conv(32'h501, 32'h1, 32'h15);
		chk(n, 32'hb);
		wr(8'h10, 32'h0);
		ci(1'h0);
		wr(8'h0c, 32'h7);
		wr(8'h10, 32'h7);
		wr(8'h00, 32'h3);
		band_gap_ok_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		rd(8'h08, 32'h4001);
		rd(8'h0c, 32'h4);
		ci(1'h1);
		band_gap_ok_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		rd(8'h08, 32'hc001);
		wr(8'h00, 32'h0);
		rd(8'h08, 32'h8001);
		wr(8'h0c, 32'h7);
		ci(1'h0);
		wr(8'h04, 32'h501);
		@(posedge clk_i);
		rst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h8000);
		end_of_test;
	end
endmodule // tb_sac_ctrl
